// File: common/eil_pkg.sv
package eil_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int          ADDR_W     = 4;
	localparam int          DATA_W     = 8;
	localparam logic [3:0]  STATCTL_OFF = 4'h0;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int          MODE_BIT   = 0;
	localparam int          MASK_BIT   = 1;
	localparam int          ACK_BIT    = 2;
	localparam int          FLAG_BIT   = 3;

	// ------------------------------------------------------------
	// reset values and warm-up limit
	// ------------------------------------------------------------
	localparam logic        MODE_RST   = 1'b0;
	localparam logic        MASK_RST   = 1'b0;
	localparam logic        LATCH_RST  = 1'b0;
	localparam logic [7:0]  RD_RST     = 8'h00;
	// last warm-up count: sync chain then holds three real samples
	localparam logic [1:0]  WARM_LAST  = 2'h3;

	// ------------------------------------------------------------
	// handler vector locations
	// ------------------------------------------------------------
	localparam logic [15:0] VEC_HI_ADDR = 16'hfffa;
	localparam logic [15:0] VEC_LO_ADDR = 16'hfffb;

	// ------------------------------------------------------------
	// clear tracking states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		EIL_IDLE,
		EIL_PEND,
		EIL_ACKED
	} eil_state_t;

endpackage

// File: design/eil_top.sv
module eil_top
	import eil_pkg::*;
(
	// clock and reset
	input  wire logic              core_clk_in,
	input  wire logic              rst_n_in,
	// interrupt pin, active low
	input  wire logic              irq_pin_n_in,
	// cpu side
	input  wire logic              vec_fetch_ack_in,
	input  wire logic              break_state_in,
	input  wire logic              break_clear_enable_in,
	output logic                   irq_req_out,
	output logic                   pending_flag_out,
	output logic [15:0]            vec_addr_hi_out,
	output logic [15:0]            vec_addr_lo_out,
	// register port
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] wr_data_in,
	input  wire logic              wr_en_in,
	input  wire logic              rd_en_in,
	output logic [DATA_W-1:0]      rd_data_out
);

	// ------------------------------------------------------------
	// pin synchroniser and edge detect
	// ------------------------------------------------------------
	logic pin_meta;
	logic pin_sync;
	logic pin_prev;
	wire  pin_fall;
	wire  pin_low;

	// pin_meta feeds only pin_sync
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_meta <= 1'b1;
			pin_sync <= 1'b1;
			pin_prev <= 1'b1;
		end else begin
			pin_meta <= irq_pin_n_in;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// ------------------------------------------------------------
	// synchroniser warm-up
	// ------------------------------------------------------------
	// edges are ignored until the chain holds real pin samples,
	// so a pin held low through reset never looks like a fall
	logic [1:0] warm_cnt;
	wire        warm_done;

	assign warm_done = (warm_cnt == WARM_LAST);

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			warm_cnt <= 2'h0;
		end else if (!warm_done) begin
			warm_cnt <= warm_cnt + 2'h1;
		end
	end

	assign pin_fall = warm_done & pin_prev & ~pin_sync;
	assign pin_low  = ~pin_sync;

	// ------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------
	function automatic logic hit(input logic [ADDR_W-1:0] a);
		hit = (a == STATCTL_OFF);
	endfunction

	logic       mode;
	logic       mask;
	logic       latch;
	eil_state_t state;
	eil_state_t next_state;

	wire        reg_wr;
	wire        reg_rd;
	wire        ack_allowed;
	wire        sw_ack;
	wire        any_ack;
	wire        clr_ok;
	wire        set_req;
	wire        next_latch;
	wire        next_mode;
	wire        next_mask;
	wire [7:0]  reg_value;

	assign reg_wr = wr_en_in & hit(addr_in);
	assign reg_rd = rd_en_in & hit(addr_in);

	// break state blocks register acks unless clearing is enabled; vector fetch acks still pass
	assign ack_allowed = ~break_state_in | break_clear_enable_in;
	assign sw_ack  = reg_wr & wr_data_in[ACK_BIT] & ack_allowed;
	assign any_ack = sw_ack | vec_fetch_ack_in;

	// ------------------------------------------------------------
	// latch control
	// ------------------------------------------------------------
	// level mode keeps the ack pending until the pin goes high,
	// so the two events may arrive in either order
	assign clr_ok = (any_ack | (state == EIL_ACKED)) &
	                (~mode | ~pin_low);

	// a new edge wins over any clear in the same cycle
	assign set_req = pin_fall | (mode & pin_low & ~latch);

	assign next_latch = set_req ? 1'b1 :
	                    (latch & clr_ok) ? 1'b0 : latch;

	assign next_mode = reg_wr ? wr_data_in[MODE_BIT] : mode;
	assign next_mask = reg_wr ? wr_data_in[MASK_BIT] : mask;

	always_comb begin
		next_state = state;
		case (state)
			EIL_IDLE: begin
				if (next_latch) begin
					next_state = EIL_PEND;
				end
			end
			EIL_PEND: begin
				if (!next_latch) begin
					next_state = EIL_IDLE;
				end else if (any_ack && !set_req) begin
					next_state = EIL_ACKED;
				end
			end
			EIL_ACKED: begin
				if (!next_latch) begin
					next_state = EIL_IDLE;
				end else if (pin_fall) begin
					next_state = EIL_PEND;
				end
			end
			default: begin
				next_state = EIL_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			latch <= LATCH_RST;
			mode  <= MODE_RST;
			mask  <= MASK_RST;
			state <= EIL_IDLE;
		end else begin
			latch <= next_latch;
			mode  <= next_mode;
			mask  <= next_mask;
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// read data and outputs
	// ------------------------------------------------------------
	// ack always reads zero, unused bits read zero
	assign reg_value = {4'h0, latch, 1'b0, mask, mode};

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_out <= RD_RST;
		end else begin
			rd_data_out <= reg_rd ? reg_value : RD_RST;
		end
	end

	// latch runs regardless of mask, only the request is gated
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_req_out      <= 1'b0;
			pending_flag_out <= 1'b0;
		end else begin
			irq_req_out      <= next_latch & ~next_mask;
			pending_flag_out <= next_latch;
		end
	end

	// fixed vector locations for the cpu fetch
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			vec_addr_hi_out <= VEC_HI_ADDR;
			vec_addr_lo_out <= VEC_LO_ADDR;
		end else begin
			vec_addr_hi_out <= VEC_HI_ADDR;
			vec_addr_lo_out <= VEC_LO_ADDR;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_edge;
		pin_fall;
	endsequence

	sequence s_level_ack;
		mode && any_ack && pin_low;
	endsequence

	sequence s_ack_no_edge;
		any_ack && !pin_fall;
	endsequence

	sequence s_break_ack;
		reg_wr && wr_data_in[ACK_BIT] && break_state_in && !break_clear_enable_in
		&& !vec_fetch_ack_in && !set_req;
	endsequence

	edge_sets_latch_a: assert property (
		s_edge |=> latch && pending_flag_out
	) else $error("falling edge did not set latch");

	edge_mode_clear_a: assert property (
		!mode ##0 s_ack_no_edge |=> !latch && !pending_flag_out
	) else $error("edge mode ack did not clear latch");

	level_hold_low_a: assert property (
		mode && latch && pin_low && !reg_wr |=> latch
	) else $error("level mode latch dropped while pin low");

	level_clear_high_a: assert property (
		mode && state == EIL_ACKED && !pin_low && !set_req && !reg_wr
		|=> !latch
	) else $error("level mode latch kept after ack and high pin");

	ack_reads_zero_a: assert property (
		reg_rd |=> rd_data_out[ACK_BIT] == 1'b0 && rd_data_out[7:4] == 4'h0
	) else $error("ack or unused bits read nonzero");

	edge_after_ack_a: assert property (
		sw_ack ##1 s_edge |=> latch
	) else $error("edge after ack was lost");

	flag_reads_latch_a: assert property (
		reg_rd |=> rd_data_out[FLAG_BIT] == $past(latch)
	) else $error("pending flag read wrong");

	break_protect_a: assert property (
		s_break_ack ##0 latch |=> latch
	) else $error("ack during break changed latch");

	break_clear_a: assert property (
		sw_ack && break_state_in && !set_req && !mode |=> !latch
	) else $error("enabled break ack did not clear");

	mask_gates_req_a: assert property (
		mask && latch && !reg_wr |=> !irq_req_out && pending_flag_out == latch
	) else $error("mask did not gate request");

	req_follows_latch_a: assert property (
		##1 irq_req_out == ($past(next_latch) && !$past(next_mask))
	) else $error("request output mismatch");

	mode_write_a: assert property (
		reg_wr |=> mode == $past(wr_data_in[MODE_BIT]) &&
		           mask == $past(wr_data_in[MASK_BIT])
	) else $error("mode bit not stored");

	vector_fixed_a: assert property (
		vec_addr_hi_out == VEC_HI_ADDR && vec_addr_lo_out == VEC_LO_ADDR
	) else $error("vector address changed");

	sync_delay_a: assert property (
		pin_sync == $past(irq_pin_n_in, 2) || $past(!rst_n_in, 2)
	) else $error("pin sync depth wrong");

	warmup_no_latch_a: assert property (
		!warm_done && !mode && !reg_wr |=> !latch
	) else $error("latch set during sync warm-up");

	rd_idle_zero_a: assert property (
		!reg_rd |=> rd_data_out == RD_RST
	) else $error("read data not zero outside read");

	rd_unmapped_a: assert property (
		rd_en_in && !reg_rd |=> rd_data_out == RD_RST
	) else $error("unmapped read returned data");

	pending_tracks_latch_a: assert property (
		pending_flag_out == latch
	) else $error("pending flag differs from latch");

	ctl_read_a: assert property (
		reg_rd |=> rd_data_out[MASK_BIT] == $past(mask) &&
		           rd_data_out[MODE_BIT] == $past(mode)
	) else $error("mask or mode read wrong");

	unmapped_write_a: assert property (
		wr_en_in && !reg_wr |=> $stable(mode) && $stable(mask)
	) else $error("unmapped write changed control");

	req_needs_latch_a: assert property (
		irq_req_out |-> pending_flag_out
	) else $error("request without pending latch");

	vec_ack_clear_a: assert property (
		vec_fetch_ack_in && !mode && !pin_fall |=> !latch
	) else $error("vector ack did not clear latch");

	level_set_low_a: assert property (
		mode && pin_low && !latch |=> latch
	) else $error("low level did not set latch");

	edge_no_level_a: assert property (
		!mode && !pin_fall && !latch |=> !latch
	) else $error("edge mode latched without edge");

	level_ack_kept_a: assert property (
		s_level_ack ##0 latch && !set_req |=> state == EIL_ACKED
	) else $error("level mode ack not remembered");

	acked_new_edge_a: assert property (
		state == EIL_ACKED && pin_fall |=> state == EIL_PEND && latch
	) else $error("edge after level ack lost");

	set_over_clear_a: assert property (
		pin_fall && any_ack |=> latch
	) else $error("clear beat a new edge");

	break_ack_gate_a: assert property (
		break_state_in && !break_clear_enable_in |-> !sw_ack
	) else $error("ack taken during protected break");

endmodule

// File: verif/eil_pin_model.sv
module eil_pin_model (
	// request from bench
	input  wire logic pull_low_in,
	// interrupt pin
	output logic      irq_pin_n_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// pin has a pull-up: a released pin reads high, never a stale value
	assign irq_pin_n_out = pull_low_in ? 1'b0 : 1'b1;
endmodule

// File: verif/tb_top.sv
module tb_top;
	import eil_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic              clk, rst_n, low, vack, brk, bce, wr, rd;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdat, rdat;
	logic [15:0]       vhi, vlo;
	logic              pin_n, req, flag;
	int                failures, samples_checked, cyc;
	logic [7:0]        row_wr [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hf4, 8'hf7};
	logic [7:0]        row_rd [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h00, 8'h03};

	eil_pin_model pin_u (.pull_low_in(low), .irq_pin_n_out(pin_n));
	eil_top dut_u (.core_clk_in(clk), .rst_n_in(rst_n), .irq_pin_n_in(pin_n),
		.vec_fetch_ack_in(vack), .break_state_in(brk), .break_clear_enable_in(bce),
		.irq_req_out(req), .pending_flag_out(flag), .vec_addr_hi_out(vhi),
		.vec_addr_lo_out(vlo), .addr_in(addr), .wr_data_in(wdat), .wr_en_in(wr),
		.rd_en_in(rd), .rd_data_out(rdat));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t bit got %b exp %b", $time, got, exp);
		end
	endtask
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t value got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic flags(input logic f, input logic r);
		chk_bit(flag, f);
		chk_bit(req, r);
	endtask
	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdat <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk_val({8'h00, rdat}, {8'h00, e});
	endtask
	task automatic pin(input logic l);
		@(posedge clk);
		low <= l;
		settle();
	endtask
	task automatic tally_and_finish();
		$display("checked %0d failed %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// hang guard: whole run is under two hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			$display("[ERR] %0t timeout", $time);
			tally_and_finish();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{rst_n, low, vack, brk, bce, wr, rd} = '0;
		addr = '0;
		wdat = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		flags(1'b0, 1'b0);
		chk_val(vhi, 16'hfffa);
		chk_val(vlo, 16'hfffb);
		reg_rd(STATCTL_OFF, 8'h00);
		for (int i = 0; i < 6; i++) begin
			reg_wr(STATCTL_OFF, row_wr[i]);
			reg_rd(STATCTL_OFF, row_rd[i]);
		end
		reg_wr(STATCTL_OFF, 8'h00);
		reg_wr(4'h1, 8'h03);
		reg_rd(STATCTL_OFF, 8'h00);
		reg_rd(4'h1, 8'h00);
		// edge mode
		pin(1'b1);
		flags(1'b1, 1'b1);
		reg_rd(STATCTL_OFF, 8'h08);
		reg_wr(STATCTL_OFF, 8'h02);
		settle();
		flags(1'b1, 1'b0);
		reg_rd(STATCTL_OFF, 8'h0a);
		reg_wr(STATCTL_OFF, 8'h04);
		chk_bit(flag, 1'b0);
		settle();
		flags(1'b0, 1'b0);
		pin(1'b0);
		pin(1'b1);
		flags(1'b1, 1'b1);
		@(posedge clk);
		vack <= 1'b1;
		@(posedge clk);
		vack <= 1'b0;
		settle();
		flags(1'b0, 1'b0);
		// level mode, pin still low
		reg_wr(STATCTL_OFF, 8'h01);
		settle();
		flags(1'b1, 1'b1);
		reg_wr(STATCTL_OFF, 8'h03);
		settle();
		flags(1'b1, 1'b0);
		reg_wr(STATCTL_OFF, 8'h05);
		settle();
		flags(1'b1, 1'b1);
		pin(1'b0);
		flags(1'b0, 1'b0);
		pin(1'b1);
		pin(1'b0);
		flags(1'b1, 1'b1);
		reg_wr(STATCTL_OFF, 8'h05);
		settle();
		flags(1'b0, 1'b0);
		// mid-run reset with the pin held low
		pin(1'b1);
		flags(1'b1, 1'b1);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		settle();
		flags(1'b0, 1'b0);
		reg_rd(STATCTL_OFF, 8'h00);
		// break state acknowledges
		pin(1'b0);
		pin(1'b1);
		@(posedge clk);
		brk <= 1'b1;
		reg_wr(STATCTL_OFF, 8'h04);
		settle();
		flags(1'b1, 1'b1);
		bce <= 1'b1;
		reg_wr(STATCTL_OFF, 8'h04);
		settle();
		flags(1'b0, 1'b0);
		brk <= 1'b0;
		settle();
		flags(1'b0, 1'b0);
		tally_and_finish();
	end
endmodule
